/* File: bspm_pin_mux.sv */
// boot strap pin function mux with an ahb-lite register slave
// Notes on behaviour
// - thirteen shared pins, each with two functions chosen at boot
// - strap bit 18 high: check bits on eight pins, else io bits 15..8
// - strap bit 9 high: dma ch2 request pin becomes codec reset output
// - strap bit 9 high: dma ch2 ack pin carries codec frame sync
// - strap bit 9 high: io bit 4 carries codec serial output
// - strap bit 9 high: io bit 3 is codec serial input 0
// - strap bit 9 high: io bit 2 is codec bit clock input
// - 66 MHz enable level one enables, zero disables
// - 66 MHz enable pin input in host mode, output in satellite mode
// - power event pin input in host mode, open drain in satellite
// - trace off: data-in feeds scan; trace on: debug interrupt cancels trace
// - trace on: data-out plus three pins give pc trace, else scan data
// - debug clock is system clock over three during monitor bus
// - low-power output high in halt or doze
// - test reset, after two sync flops, clears trace and its ctrl bit
// - test reset de-asserted disables system-bus timeout detection
`include "bspm_consts.svh"
module bspm_pin_mux (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // strap pins, sampled during reset
   input wire logic [19:0] strap_addr,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // internal function sources
   input wire logic [7:0] cb_out_int,
   input wire logic cb_oe_int,
   input wire logic [15:8] pio_hi_out_int,
   input wire logic [15:8] pio_hi_oe_int,
   input wire logic [4:2] pio_lo_out_int,
   input wire logic [4:2] pio_lo_oe_int,
   input wire logic codec_reset_n_int,
   input wire logic codec_sync_int,
   input wire logic codec_sdout_int,
   input wire logic dma_ch2_ack_int,
   input wire logic [3:0] pc_trace_int,
   input wire logic scan_data_int,
   input wire logic [8:0] trace_status_int,
   // shared pins, three signals each except the output-only dma_ch2_ack_out
   input wire logic [7:0] sdram_check_bits_i,
   output logic [7:0] sdram_check_bits_o,
   output logic [7:0] sdram_check_bits_oe,
   input wire logic dma_ch2_request_in_i,
   output logic codec_reset_out_o,
   output logic codec_reset_out_oe,
   output logic dma_ch2_ack_out,
   input wire logic [4:2] parallel_io_bits_i,
   output logic [4:2] parallel_io_bits_o,
   output logic [4:2] parallel_io_bits_oe,
   input wire logic m66_enable_i,
   output logic m66_enable_o,
   output logic m66_enable_oe,
   input wire logic pme_n_i,
   output logic pme_n_o,
   output logic pme_n_oe,
   // debug pins
   input wire logic test_reset_n,
   input wire logic scan_data_in,
   output logic scan_data_to_tap,
   output logic debug_interrupt_n_in,
   output logic [3:0] pc_trace_out,
   output logic debug_clock_out,
   output logic [8:0] trace_status_out,
   output logic low_power_state_out,
   output logic bus_timeout_en,
   // decoded function outputs to internal logic
   output logic [7:0] cb_in_int,
   output logic [15:8] pio_hi_in_int,
   output logic [4:2] pio_lo_in_int,
   output logic dma_ch2_req_int,
   output logic codec_sdin_int,
   output logic codec_bitclk_int,
   output logic m66_mode_int,
   output logic pme_in_int
);
   // strap capture: rst is asynchronous, so the level is sampled by a clocked
   // process while rst stands and frozen after release
   logic [2:0] strap_s1_q, strap_s2_q, strap_q;
   logic [2:0] strap_d;
   bspm_pkg::bspm_sel_type sel;

   always_comb begin
      strap_d = strap_q;
      if (rst) begin
         strap_d = strap_s2_q;
      end
   end

   // the sampler runs on its own so it keeps moving while rst is high
   always_ff @(posedge sys_clk) begin
      strap_s1_q <= {strap_addr[`BSPM_STRAP_ECC_BIT], strap_addr[`BSPM_STRAP_CODEC_BIT],
                     strap_addr[`BSPM_STRAP_SAT_BIT]};
      strap_s2_q <= strap_s1_q;
   end

   always_ff @(posedge sys_clk) begin
      strap_q <= strap_d;
   end

   assign sel = bspm_pkg::bspm_sel_type'(strap_q);

   // pin input synchronisers
   logic [15:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= 16'h0000;
         pin_s2_q <= 16'h0000;
      end else begin
         pin_s1_q <= {sdram_check_bits_i, dma_ch2_request_in_i, parallel_io_bits_i,
                      m66_enable_i, pme_n_i, scan_data_in, test_reset_n};
         pin_s2_q <= pin_s1_q;
      end
   end
   logic [7:0] cb_pin;
   logic req_pin, m66_pin, pme_pin, tdi_pin, trst_pin;
   logic [4:2] pio_pin;
   assign {cb_pin, req_pin, pio_pin, m66_pin, pme_pin, tdi_pin, trst_pin} = pin_s2_q;

   // ahb-lite slave: zero wait state, always okay
   bspm_pkg::bspm_ahb_req_type req_q, req_d;
   logic [4:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic trace_q, trace_d;
   logic wr_phase;
   logic ready_q, resp_q;

   assign wr_phase = req_q.hsel && req_q.htrans[1] && req_q.hwrite;

   always_comb begin
      req_d = req_q;
      if (hready) begin
         req_d = '{haddr: haddr, hwrite: hwrite, hsize: hsize, htrans: htrans, hsel: hsel};
      end
      ctrl_d = ctrl_q;
      if (wr_phase && req_q.haddr == `BSPM_OFF_CTRL) begin
         ctrl_d = hwdata[4:0];
      end
      // debug interrupt (low) cancels trace once it is on; a set by software wins
      // over a pending interrupt only while trace is off
      trace_d = ctrl_d[`BSPM_CTRL_TRACE_BIT];
      if (trace_q && !tdi_pin) begin
         trace_d = 1'b0;
         ctrl_d[`BSPM_CTRL_TRACE_BIT] = 1'b0;
      end
      if (!trst_pin) begin
         trace_d = 1'b0;
         ctrl_d[`BSPM_CTRL_TRACE_BIT] = 1'b0;
      end
      rdata_d = 32'h0000_0000;
      if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr)
            `BSPM_OFF_STRAPS: rdata_d = {29'h0, sel.ecc_mode, sel.codec_mode, sel.satellite_mode};
            `BSPM_OFF_CTRL: rdata_d = {27'h0, ctrl_d};
            `BSPM_OFF_STATUS: rdata_d = {28'h0, m66_mode_int, pme_in_int, trst_pin, trace_d};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
         ctrl_q <= `BSPM_CTRL_RESET;
         trace_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b1;
         resp_q <= 1'b0;
      end else begin
         req_q <= req_d;
         ctrl_q <= ctrl_d;
         trace_q <= trace_d;
         rdata_q <= rdata_d;
         ready_q <= 1'b1;
         resp_q <= 1'b0;
      end
   end

   assign hrdata = rdata_q;
   assign hreadyout = ready_q;
   assign hresp = resp_q;

   // debug clock divider
   logic debug_clock_out_lvl;
   logic monbus_run;
   assign monbus_run = ctrl_q[`BSPM_CTRL_MONBUS_BIT] || trace_q;
   bspm_debug_clock_out_div u_debug_clock_out_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(monbus_run),
      .tick(),
      .debug_clock_out_level(debug_clock_out_lvl)
   );

   // registered pin drive
   logic [37:0] pin_q, pin_d;
   always_comb begin
      pin_d = '0;
      // check bits versus io 15..8 share one set of eight pins
      if (sel.ecc_mode) begin
         pin_d[7:0] = cb_out_int;
         pin_d[15:8] = {8{cb_oe_int}};
      end else begin
         pin_d[7:0] = pio_hi_out_int;
         pin_d[15:8] = pio_hi_oe_int;
      end
      // dma request versus codec reset; ack versus sync
      pin_d[16] = codec_reset_n_int;
      pin_d[17] = sel.codec_mode;
      pin_d[18] = sel.codec_mode ? codec_sync_int : dma_ch2_ack_int;
      // io 4..2 versus codec sdout, sdin, bitclk
      if (sel.codec_mode) begin
         pin_d[21:19] = {codec_sdout_int, 2'b00};
         pin_d[24:22] = 3'b100;
      end else begin
         pin_d[21:19] = pio_lo_out_int;
         pin_d[24:22] = pio_lo_oe_int;
      end
      // satellite drives m66 and, with the ctrl pme bit set, pulls pme low open drain
      pin_d[25] = ctrl_q[`BSPM_CTRL_M66_BIT];
      pin_d[26] = sel.satellite_mode;
      pin_d[27] = 1'b0;
      pin_d[28] = sel.satellite_mode && ctrl_q[`BSPM_CTRL_PME_BIT];
      pin_d[32:29] = trace_q ? pc_trace_int : {3'b000, scan_data_int};
      pin_d[33] = trace_q ? debug_clock_out_lvl : 1'b0;
      if (ctrl_q[`BSPM_CTRL_MONBUS_BIT]) begin
         pin_d[33] = debug_clock_out_lvl;
      end
      pin_d[34] = ctrl_q[`BSPM_CTRL_LOWPWR_BIT];
      // test reset released turns system-bus timeout detection off
      pin_d[35] = !trst_pin;
      pin_d[36] = trace_q ? 1'b1 : tdi_pin;
      pin_d[37] = trace_q ? tdi_pin : 1'b1;
   end

   logic [8:0] pcst_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_q <= '0;
         pcst_q <= 9'h000;
      end else begin
         pin_q <= pin_d;
         pcst_q <= (trace_q || ctrl_q[`BSPM_CTRL_MONBUS_BIT]) ? trace_status_int : 9'h000;
      end
   end

   assign sdram_check_bits_o = pin_q[7:0];
   assign sdram_check_bits_oe = pin_q[15:8];
   assign codec_reset_out_o = pin_q[16];
   assign codec_reset_out_oe = pin_q[17];
   assign dma_ch2_ack_out = pin_q[18];
   assign parallel_io_bits_o = pin_q[21:19];
   assign parallel_io_bits_oe = pin_q[24:22];
   assign m66_enable_o = pin_q[25];
   assign m66_enable_oe = pin_q[26];
   assign pme_n_o = pin_q[27];
   assign pme_n_oe = pin_q[28];
   assign pc_trace_out = pin_q[32:29];
   assign debug_clock_out = pin_q[33];
   assign low_power_state_out = pin_q[34];
   assign bus_timeout_en = pin_q[35];
   assign scan_data_to_tap = pin_q[36];
   assign debug_interrupt_n_in = pin_q[37];
   assign trace_status_out = pcst_q;

   // inputs routed to the selected internal function; registered so every
   // output leaves a flop, at the price of one more cycle of input latency
   logic [7:0] cb_in_q, cb_in_d;
   logic [15:8] pio_hi_in_q, pio_hi_in_d;
   logic [4:2] pio_lo_in_q, pio_lo_in_d;
   logic req_in_q, req_in_d;
   logic sdin_q, sdin_d;
   logic bitclk_q, bitclk_d;
   logic m66_mode_q, m66_mode_d;
   logic pme_in_q, pme_in_d;

   always_comb begin
      cb_in_d = sel.ecc_mode ? cb_pin : 8'h00;
      pio_hi_in_d = sel.ecc_mode ? 8'h00 : cb_pin;
      req_in_d = sel.codec_mode ? 1'b0 : req_pin;
      sdin_d = sel.codec_mode ? pio_pin[3] : 1'b0;
      bitclk_d = sel.codec_mode ? pio_pin[2] : 1'b0;
      pio_lo_in_d = sel.codec_mode ? 3'h0 : pio_pin;
      m66_mode_d = sel.satellite_mode ? ctrl_q[`BSPM_CTRL_M66_BIT] :
                   (m66_pin == `BSPM_M66_ENABLE);
      pme_in_d = sel.satellite_mode ? 1'b0 : !pme_pin;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cb_in_q <= 8'h00;
         pio_hi_in_q <= 8'h00;
         pio_lo_in_q <= 3'h0;
         req_in_q <= 1'b0;
         sdin_q <= 1'b0;
         bitclk_q <= 1'b0;
         m66_mode_q <= 1'b0;
         pme_in_q <= 1'b0;
      end else begin
         cb_in_q <= cb_in_d;
         pio_hi_in_q <= pio_hi_in_d;
         pio_lo_in_q <= pio_lo_in_d;
         req_in_q <= req_in_d;
         sdin_q <= sdin_d;
         bitclk_q <= bitclk_d;
         m66_mode_q <= m66_mode_d;
         pme_in_q <= pme_in_d;
      end
   end

   assign cb_in_int = cb_in_q;
   assign pio_hi_in_int = pio_hi_in_q;
   assign pio_lo_in_int = pio_lo_in_q;
   assign dma_ch2_req_int = req_in_q;
   assign codec_sdin_int = sdin_q;
   assign codec_bitclk_int = bitclk_q;
   assign m66_mode_int = m66_mode_q;
   assign pme_in_int = pme_in_q;
endmodule

/* File: bspm_consts.svh */
// constants for the boot strap pin function mux
`ifndef BSPM_CONSTS_SVH
`define BSPM_CONSTS_SVH
`define BSPM_NUM_MUX_PINS 13
`define BSPM_CB_WIDTH 8
`define BSPM_STRAP_ECC_BIT 18
`define BSPM_STRAP_CODEC_BIT 9
`define BSPM_STRAP_SAT_BIT 19
`define BSPM_STRAP_MASK 20'h0c0200
`define BSPM_DEBUG_CLOCK_OUT_DIV 3
`define BSPM_RST_SEL_ECC 1'b0
`define BSPM_RST_SEL_CODEC 1'b0
`define BSPM_RST_SEL_SAT 1'b0
`define BSPM_M66_ENABLE 1'b1
`define BSPM_OFF_STRAPS 32'h0000_0000
`define BSPM_OFF_CTRL 32'h0000_0004
`define BSPM_OFF_STATUS 32'h0000_0008
`define BSPM_CTRL_TRACE_BIT 0
`define BSPM_CTRL_MONBUS_BIT 1
`define BSPM_CTRL_LOWPWR_BIT 2
`define BSPM_CTRL_M66_BIT 3
`define BSPM_CTRL_PME_BIT 4
`define BSPM_CTRL_RESET 5'h00
`endif

/* File: bspm_pkg.sv */
// types for the boot strap pin function mux
package bspm_pkg;
   typedef struct packed {
      logic ecc_mode;
      logic codec_mode;
      logic satellite_mode;
   } bspm_sel_type;
   typedef struct packed {
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [1:0] htrans;
      logic hsel;
   } bspm_ahb_req_type;
endpackage

/* File: bspm_debug_clock_out_div.sv */
// debug clock divider: one-cycle enable every third sys_clk while running
`include "bspm_consts.svh"
module bspm_debug_clock_out_div (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic run,
   // outputs
   output logic tick,
   output logic debug_clock_out_level
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic lvl_q;
   logic lvl_d;

   always_comb begin
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      if (!run) begin
         cnt_d = 2'h0;
         lvl_d = 1'b0;
      end else if (cnt_q == 2'(`BSPM_DEBUG_CLOCK_OUT_DIV - 1)) begin
         cnt_d = 2'h0;
         lvl_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 2'h1;
         // high for one cycle in three, so the pin reads as a one-third rate pulse
         lvl_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 2'h0;
         lvl_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
      end
   end

   assign tick = run && (cnt_q == 2'(`BSPM_DEBUG_CLOCK_OUT_DIV - 1));
   assign debug_clock_out_level = lvl_q;
endmodule

/* File: bspm_pin_mux_sva.sv */
// assertion checker for the boot strap pin function mux
module bspm_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // watched ports
   input wire logic codec_reset_out_oe,
   input wire logic [4:2] parallel_io_bits_oe,
   input wire logic m66_enable_i,
   input wire logic m66_enable_oe,
   input wire logic m66_mode_int,
   input wire logic pme_n_o,
   input wire logic pme_n_oe,
   input wire logic debug_clock_out,
   input wire logic test_reset_n,
   input wire logic debug_interrupt_n_in,
   input wire logic bus_timeout_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_pio_dir;
      codec_reset_out_oe |-> parallel_io_bits_oe == 3'b100;
   endproperty
   a_pio_dir: assert property (p_pio_dir) else $error("pio direction wrong");
   property p_sel_hold;
      !$fell(codec_reset_out_oe) && !$fell(m66_enable_oe);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("selection moved");
   property p_pme_od;
      pme_n_oe |-> !pme_n_o;
   endproperty
   a_pme_od: assert property (p_pme_od) else $error("pme drives high");
   property p_debug_clock_out;
      debug_clock_out |=> !debug_clock_out [*2];
   endproperty
   a_debug_clock_out: assert property (p_debug_clock_out) else $error("debug clock ratio");
   property p_debug_interrupt_in;
      !debug_interrupt_n_in |-> ##[1:2] debug_interrupt_n_in;
   endproperty
   a_debug_interrupt_in: assert property (p_debug_interrupt_in) else $error("trace not cancelled");
   property p_trst_trace;
      !test_reset_n [*6] |-> debug_interrupt_n_in;
   endproperty
   a_trst_trace: assert property (p_trst_trace) else $error("trace kept in test reset");
   property p_trst_timeout;
      test_reset_n [*6] |-> !bus_timeout_en;
   endproperty
   a_trst_timeout: assert property (p_trst_timeout) else $error("timeout on");
   property p_m66_in;
      (!m66_enable_oe && m66_enable_i) [*4] |-> m66_mode_int;
   endproperty
   a_m66_in: assert property (p_m66_in) else $error("66 MHz level lost");
endmodule

bind bspm_pin_mux bspm_chk i_chk (.sys_clk(sys_clk), .rst(rst),
   .codec_reset_out_oe(codec_reset_out_oe), .parallel_io_bits_oe(parallel_io_bits_oe),
   .m66_enable_i(m66_enable_i), .m66_enable_oe(m66_enable_oe), .m66_mode_int(m66_mode_int),
   .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .debug_clock_out(debug_clock_out),
   .test_reset_n(test_reset_n), .debug_interrupt_n_in(debug_interrupt_n_in),
   .bus_timeout_en(bus_timeout_en));

/* File: bspm_board.sv */
// board model: peripherals drive released pins, pull-up on the power event line
module bspm_board (
   // device drive
   input wire logic [7:0] cb_o,
   input wire logic [7:0] cb_oe,
   input wire logic rq_o,
   input wire logic rq_oe,
   input wire logic [4:2] pio_o,
   input wire logic [4:2] pio_oe,
   input wire logic m66_o,
   input wire logic m66_oe,
   input wire logic pme_o,
   input wire logic pme_oe,
   // peripheral drive
   input wire logic [12:0] drv,
   // pin levels
   output logic [7:0] cb_i,
   output logic rq_i,
   output logic [4:2] pio_i,
   output logic m66_i,
   output logic pme_i
);
   always_comb begin
      cb_i = (cb_oe & cb_o) | (~cb_oe & drv[7:0]);
      rq_i = rq_oe ? rq_o : drv[8];
      pio_i = (pio_oe & pio_o) | (~pio_oe & drv[11:9]);
      m66_i = m66_oe ? m66_o : drv[12];
      // open drain: only a low is driven, the pull-up gives the high
      pme_i = !(pme_oe && !pme_o);
   end
endmodule

/* File: bspm_pin_mux_tb.sv */
// self-checking testbench for the boot strap pin function mux
module bspm_pin_mux_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize, s;
   logic [19:0] strap_addr;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0] cb_out_int, pio_hi_out_int, pio_hi_oe_int, cb_in_int, pio_hi_in_int;
   logic [7:0] sdram_check_bits_i, sdram_check_bits_o, sdram_check_bits_oe;
   logic [4:2] pio_lo_out_int, pio_lo_oe_int, pio_lo_in_int;
   logic [4:2] parallel_io_bits_i, parallel_io_bits_o, parallel_io_bits_oe;
   logic [3:0] pc_trace_int, pc_trace_out;
   logic [8:0] trace_status_int, trace_status_out;
   logic cb_oe_int, codec_reset_n_int, codec_sync_int, codec_sdout_int, dma_ch2_ack_int;
   logic scan_data_int, dma_ch2_request_in_i, codec_reset_out_o, codec_reset_out_oe;
   logic dma_ch2_ack_out, m66_enable_i, m66_enable_o, m66_enable_oe, pme_n_i, pme_n_o;
   logic pme_n_oe, test_reset_n, scan_data_in, scan_data_to_tap, debug_interrupt_n_in;
   logic debug_clock_out, low_power_state_out, bus_timeout_en, dma_ch2_req_int;
   logic codec_sdin_int, codec_bitclk_int, m66_mode_int, pme_in_int;
   logic [12:0] drv;
   logic [63:0] rnd = '0;
   int err_total = 0, n_tests = 0, k, hits;
   assign hready = hreadyout;
   assign {cb_out_int, cb_oe_int, pio_hi_out_int, pio_hi_oe_int, pio_lo_out_int, pio_lo_oe_int,
      codec_reset_n_int, codec_sync_int, codec_sdout_int, dma_ch2_ack_int, pc_trace_int,
      scan_data_int, trace_status_int, drv} = rnd[61:0];
   bspm_pin_mux i_bspm_pin_mux (.*);
   bspm_board i_bspm_board (.cb_o(sdram_check_bits_o), .cb_oe(sdram_check_bits_oe),
      .rq_o(codec_reset_out_o), .rq_oe(codec_reset_out_oe), .pio_o(parallel_io_bits_o),
      .pio_oe(parallel_io_bits_oe), .m66_o(m66_enable_o), .m66_oe(m66_enable_oe),
      .pme_o(pme_n_o), .pme_oe(pme_n_oe), .drv(drv), .cb_i(sdram_check_bits_i),
      .rq_i(dma_ch2_request_in_i), .pio_i(parallel_io_bits_i), .m66_i(m66_enable_i),
      .pme_i(pme_n_i));
   always #4 sys_clk = ~sys_clk;
   task complete_run;
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // bounded wait for hready at a rising edge
   task wt;
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) break;
      end
      if (k == 20) begin
         err_total++;
         complete_run();
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      wt();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wt();
      rd = hrdata;
   endtask
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, test_reset_n, scan_data_in, strap_addr} = '0;
      hsize = 3'b010;
      void'($urandom(42729));
      for (int m = 0; m < 8; m++) begin
         s = m[2:0];
         rst <= 1'b1;
         // straps held steady for the whole reset
         strap_addr <= (20'($urandom) & 20'h3fdff) | {s[0], s[2], 8'h00, s[1], 9'h000};
         repeat (8) @(posedge sys_clk);
         rst <= 1'b0;
         @(posedge sys_clk);
         strap_addr <= ~strap_addr;
         rnd <= {$urandom, $urandom};
         // pin inputs pass two sync flops and an output register
         repeat (6) @(posedge sys_clk);
         check(sdram_check_bits_oe, s[2] ? {8{cb_oe_int}} : pio_hi_oe_int);
         check(sdram_check_bits_o, s[2] ? cb_out_int : pio_hi_out_int);
         check(s[2] ? cb_in_int : pio_hi_in_int, sdram_check_bits_i);
         check(codec_reset_out_oe, s[1]);
         check(s[1] ? codec_reset_out_o : dma_ch2_req_int, s[1] ? codec_reset_n_int : drv[8]);
         check(dma_ch2_ack_out, s[1] ? codec_sync_int : dma_ch2_ack_int);
         check(parallel_io_bits_oe, s[1] ? 3'b100 : pio_lo_oe_int);
         check(parallel_io_bits_o[4], s[1] ? codec_sdout_int : pio_lo_out_int[4]);
         check(s[1] ? {codec_sdin_int, codec_bitclk_int} : pio_lo_in_int[3:2],
            parallel_io_bits_i[3:2]);
         check({m66_enable_oe, pme_n_oe}, {s[0], 1'b0});
         check(s[0] | m66_mode_int, s[0] | drv[12]);
         check(pme_in_int, s[0] ? 1'b0 : !pme_n_i);
         ahb(1'b0, 32'h0, 32'h0);
         check(rd, {29'h0, s});
         ahb(1'b0, 32'hc, 32'h0);
         check(rd, 32'h0);
         check(32'(hresp), 32'h0);
         if (s[0]) begin
            ahb(1'b1, 32'h4, 32'h18);
            repeat (2) @(posedge sys_clk);
            check({m66_enable_o, pme_n_oe, pme_n_i}, 3'b110);
            ahb(1'b1, 32'h4, 32'h0);
         end
      end
      test_reset_n <= 1'b1;
      scan_data_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ahb(1'b1, 32'h4, 32'h1);
      repeat (4) @(posedge sys_clk);
      check({pc_trace_out, scan_data_to_tap, bus_timeout_en}, {pc_trace_int, 2'b10});
      scan_data_in <= 1'b0;
      repeat (5) @(posedge sys_clk);
      check({pc_trace_out[0], scan_data_to_tap, debug_interrupt_n_in}, {scan_data_int, 2'b01});
      scan_data_in <= 1'b1;
      ahb(1'b1, 32'h4, 32'h1);
      test_reset_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      ahb(1'b0, 32'h8, 32'h0);
      check(rd[1:0], 2'b00);
      test_reset_n <= 1'b1;
      ahb(1'b1, 32'h4, 32'h6);
      repeat (3) @(posedge sys_clk);
      hits = 0;
      repeat (30) begin
         @(posedge sys_clk);
         hits += debug_clock_out;
      end
      check(32'(hits), 32'd10);
      check(trace_status_out, trace_status_int);
      check(low_power_state_out, 1'b1);
      ahb(1'b1, 32'h4, 32'h0);
      repeat (3) @(posedge sys_clk);
      check({debug_clock_out, low_power_state_out, trace_status_out}, 11'h000);
      complete_run();
   end
endmodule
